// >>> src/idst_defs.svh
// Constants for the I/O delay and serdes tile
// Included by bare name from the tile's package and modules
`ifndef IDST_DEFS_SVH
`define IDST_DEFS_SVH

// Delay line: tap count and tap loaded at configuration
`define IDST_TAP_DEPTH 256
`define IDST_TAP_INIT 0

// Serdes parallel widths
`define IDST_W_MIN 4'h2
`define IDST_W_MAX1 4'h4
`define IDST_W_MAX2 4'h8
`define IDST_WORD_W 8
`define IDST_PINS 2

`endif

// >>> src/idst_pkg.sv
// Types shared by the I/O delay and serdes tile
// Assumes idst_defs.svh on the include path
`include "idst_defs.svh"

package idst_pkg;

  // Quasi-static configuration from the core side
  typedef struct packed {
    logic       ser_en;
    logic       in_reg;
    logic       out_reg;
    logic       ddr_en;
    logic       diff_en;
    logic       pd_en;
    logic       dbl_src;
    logic       out_en;
    logic [3:0] width;
  } idst_cfg_t;

  // One-cycle delay requests in the link domain
  typedef struct packed {
    logic inc;
    logic dec;
    logic cal;
  } idst_tap_req_t;

  // Pin drive: levels and enables
  typedef struct packed {
    logic [`IDST_PINS-1:0] o;
    logic [`IDST_PINS-1:0] oe;
  } idst_pin_t;

  // Half-period calibration walk
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_WAIT = 2'b01,
    CAL_CNT  = 2'b11,
    CAL_LOAD = 2'b10
  } idst_cal_t;

endpackage

// >>> src/idst_tap_line.sv
// One pin's tap delay line with step, calibration and phase detector
// Assumes io_clk as tap clock and rst_n already synchronised to it
`timescale 1ns/1ps
`default_nettype none
`include "idst_defs.svh"

module idst_tap_line
  import idst_pkg::*;
#(
  parameter int DEPTH = `IDST_TAP_DEPTH,
  parameter int INIT  = `IDST_TAP_INIT
) (
  // Link clock and reset
  input  wire logic                     io_clk,
  input  wire logic                     rst_n,
  // Data
  input  wire logic                     dir_out,
  input  wire logic                     din_in,
  input  wire logic                     din_out,
  output logic                          dout,
  // Control and state
  input  wire logic                     strobe,
  input  wire idst_tap_req_t            req,
  input  wire logic                     pd_en,
  output logic [$clog2(DEPTH)-1:0]      tap,
  output logic                          cal_busy
);

  localparam int TW = $clog2(DEPTH);
  localparam logic [TW-1:0] TMAX = TW'(DEPTH - 1);

  if (DEPTH < 4 || (1 << TW) != DEPTH || INIT >= DEPTH) begin : g_bad
    $error("tap depth must be a power of two of at least 4");
  end

  logic [DEPTH-1:0] line_r;
  logic [TW-1:0]    tap_r;
  logic [TW-1:0]    tap_nxt;
  logic [TW-1:0]    cnt_r;
  logic [TW-1:0]    cnt_nxt;
  idst_cal_t        st_r;
  idst_cal_t        st_nxt;

  // ****************************************
  // Shared line and phase detector
  // ****************************************
  // (R4) (R5) Direction steers line
  wire logic din   = dir_out ? din_out : din_in;
  wire logic s_new = (tap_r == '0) ? din : line_r[tap_r - 1'b1];
  wire logic s_mid = line_r[tap_r];
  wire logic s_old = (tap_r == TMAX) ? s_mid : line_r[tap_r + 1'b1];
  // (R8) Edge near sample
  wire logic pd_hit = pd_en && !dir_out && strobe && (s_new != s_old);
  wire logic pd_up  = pd_hit && (s_mid == s_old);
  wire logic pd_dn  = pd_hit && (s_mid != s_old);

  assign dout     = s_mid;
  assign tap      = tap_r;
  assign cal_busy = (st_r != CAL_IDLE);

  // (R19) Saturating step
  function automatic logic [TW-1:0] f_step(input logic [TW-1:0] v,
                                           input logic up, input logic dn);
    f_step = v;
    if (up && v != TMAX) f_step = v + 1'b1;
    else if (dn && v != '0) f_step = v - 1'b1;
  endfunction

  // ****************************************
  // Tap update and calibration
  // ****************************************
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    // (R6) (R9) One tap per step
    tap_nxt = f_step(tap_r, req.inc || (pd_up && !req.dec),
                     req.dec || (pd_dn && !req.inc));
    case (st_r)
      CAL_IDLE: begin
        if (req.cal) st_nxt = CAL_WAIT;
      end
      CAL_WAIT: begin
        if (strobe) begin
          st_nxt  = CAL_CNT;
          cnt_nxt = '0;
        end
      end
      // (R7) Count one period
      CAL_CNT: begin
        if (cnt_r != TMAX) cnt_nxt = cnt_r + 1'b1;
        if (strobe) st_nxt = CAL_LOAD;
      end
      // (R7) (R18) Load half, rounded down
      CAL_LOAD: begin
        tap_nxt = cnt_r >> 1;
        st_nxt  = CAL_IDLE;
      end
      default: st_nxt = CAL_IDLE;
    endcase
  end

  // (R6) Tap from configuration
  always_ff @(posedge io_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_r <= '0;
      tap_r  <= TW'(INIT);
      cnt_r  <= '0;
      st_r   <= CAL_IDLE;
    end else begin
      line_r <= {line_r[DEPTH-2:0], din};
      tap_r  <= tap_nxt;
      cnt_r  <= cnt_nxt;
      st_r   <= st_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_sat_hi;
    @(posedge io_clk) disable iff (!rst_n)
    (tap_r == TMAX) && req.inc && (st_r != CAL_LOAD) |=> tap_r == TMAX;
  endproperty
  a_sat_hi: assert property (p_sat_hi) else $error("tap wrapped above top"); // (R19)

  property p_pd_up;
    @(posedge io_clk) disable iff (!rst_n)
    pd_up && !req.inc && !req.dec && (tap_r != TMAX) && (st_r != CAL_LOAD)
      |=> tap_r == $past(tap_r) + 1'b1;
  endproperty
  a_pd_up: assert property (p_pd_up) else $error("detector step not one tap"); // (R9)

  property p_cal_half;
    @(posedge io_clk) disable iff (!rst_n)
    st_r == CAL_LOAD |=> tap_r == ($past(cnt_r) >> 1);
  endproperty
  a_cal_half: assert property (p_cal_half) else $error("calibration not half"); // (R7)

  property p_dir;
    @(posedge io_clk) disable iff (!rst_n)
    dir_out |=> line_r[0] == $past(din_out);
  endproperty
  a_dir: assert property (p_dir) else $error("line not on output path"); // (R5)

endmodule

`default_nettype wire

// >>> src/idst_tile.sv
// I/O delay and serdes tile for two pins of a pair
// Assumes a fast single-rate io_clk unrelated to the core clock
`timescale 1ns/1ps
`default_nettype none
`include "idst_defs.svh"

// Summary of operation
// (R1) Each input and output path selects combinational or registered.
// (R2) Double data rate: one bit per edge of the partner clock.
// (R3) Each pin delayable by up to 256 taps.
// (R4) One delay value serves input or output path of a pin.
// (R5) Delay follows pin direction automatically on a two-way line.
// (R6) Tap count starts at configured value; increment and decrement at run time.
// (R7) Calibration measures taps per period and loads half of it.
// (R8) Phase detector mode exists only on differential inputs.
// (R9) Phase detector steps input delay one tap per adjustment.
// (R10) Each input deserialises to 2, 3 or 4 bits.
// (R11) Differential inputs cascade both deserialisers for 5 to 8 bits.
// (R12) Each output serialises words of 2, 3 or 4 bits.
// (R13) Differential driver cascades both serialisers for 5 to 8 bits.
// (R14) Serdes bits shift at single rate on one clock edge.
// (R15) Shift rate from synthesiser clock or both edges of incoming clock.
// (R16) Single-ended outputs drive high, low or high impedance.
// (R17) Every pin has both input and output logic.
// (R18) Odd calibration count rounds the half down.
// (R19) Tap steps saturate at both ends.
module idst_tile
  import idst_pkg::*;
#(
  parameter int TAP_DEPTH = `IDST_TAP_DEPTH,
  parameter int TAP_INIT  = `IDST_TAP_INIT
) (
  // Core clock and reset
  input  wire logic                               clock,
  input  wire logic                               arst_n,
  // Core-side configuration and delay control
  input  wire idst_cfg_t                          cfg,
  input  wire logic [`IDST_PINS-1:0]              tap_inc,
  input  wire logic [`IDST_PINS-1:0]              tap_dec,
  input  wire logic [`IDST_PINS-1:0]              cal_start,
  output logic                                    cal_busy,
  // Core-side parallel words
  input  wire logic [`IDST_WORD_W-1:0]            tx_word,
  input  wire logic                               tx_valid,
  output logic                                    tx_ready,
  output logic [`IDST_WORD_W-1:0]                 rx_word,
  output logic                                    rx_valid,
  // Link clock and direct bit paths
  input  wire logic                               io_clk,
  input  wire logic [`IDST_PINS-1:0]              tx_bit,
  output logic [`IDST_PINS-1:0]                   rx_bit,
  output logic [`IDST_PINS-1:0][$clog2(TAP_DEPTH)-1:0] tap_value,
  // Pins
  input  wire logic                               ddr_clk_i,
  input  wire logic [`IDST_PINS-1:0]              pin_i,
  output idst_pin_t                               pins
);

  localparam int NP = `IDST_PINS;
  localparam int WW = `IDST_WORD_W;

  if (NP != 2 || WW != 8) begin : g_bad
    $error("tile is built for one pin pair and 8-bit words");
  end

  // ****************************************
  // Helpers
  // ****************************************
  // (R2) (R10) (R11) Width limits
  function automatic logic [3:0] f_weff(input idst_cfg_t c);
    if (c.ddr_en) f_weff = `IDST_W_MIN;
    else if (c.width < `IDST_W_MIN) f_weff = `IDST_W_MIN;
    else if (!c.diff_en && c.width > `IDST_W_MAX1) f_weff = `IDST_W_MAX1;
    else if (c.width > `IDST_W_MAX2) f_weff = `IDST_W_MAX2;
    else f_weff = c.width;
  endfunction

  function automatic logic [WW-1:0] f_mask(input logic [3:0] w);
    f_mask = WW'((16'h0001 << w) - 16'h0001);
  endfunction

  // ****************************************
  // Core-side registers
  // ****************************************
  logic [3*NP-1:0] qt_r;
  logic [WW-1:0]   txh_r;
  logic            txq_r;
  logic            ack_s1_r;
  logic            ack_s2_r;
  logic            rxt_s1_r;
  logic            rxt_s2_r;
  logic            rxt_s3_r;
  logic [WW-1:0]   rx_word_r;
  logic            rx_valid_r;
  logic            busy_s1_r;
  logic            busy_s2_r;

  // ****************************************
  // Link-side registers
  // ****************************************
  logic            lrst_s1_r;
  logic            lrst_n_r;
  idst_cfg_t       cfg_s1_r;
  idst_cfg_t       cfg_l;
  logic [3*NP-1:0] qs1_r;
  logic [3*NP-1:0] qs2_r;
  logic [3*NP-1:0] qs3_r;
  logic [NP-1:0]   pin_s1_r;
  logic [NP-1:0]   pin_s2_r;
  logic            ck_s1_r;
  logic            ck_s2_r;
  logic            ck_s3_r;
  logic            txq_s1_r;
  logic            txq_s2_r;
  logic            ack_r;
  logic            pend_r;
  logic [WW-1:0]   pw_r;
  logic [3:0]      cnt_r;
  logic [3:0]      cnt_nxt;
  logic [3:0]      ds0_r;
  logic [3:0]      ds1_r;
  logic [WW-1:0]   sreg_r;
  logic [WW-1:0]   sreg_nxt;
  logic [WW-1:0]   rxh_r;
  logic            rxt_r;
  logic [NP-1:0]   rxb_r;
  logic [NP-1:0]   o_r;

  // ****************************************
  // Link-side decode
  // ****************************************
  wire logic [3*NP-1:0] qp    = qs2_r ^ qs3_r;
  wire logic [3:0]      weff  = f_weff(cfg_l);
  wire logic            cas   = cfg_l.diff_en && (weff > `IDST_W_MAX1);
  wire logic            dir   = cfg_l.out_en;
  // (R15) Synthesiser rate or both edges
  wire logic            strobe = cfg_l.dbl_src ? (ck_s2_r ^ ck_s3_r) : 1'b1;
  wire logic            bnd   = strobe && (cnt_r == weff - 4'h1);
  wire logic            take  = (txq_s2_r != ack_r) && !pend_r;
  wire logic [NP-1:0]   dly;
  wire logic [NP-1:0]   d_in  = cfg_l.diff_en ? {NP{dly[0]}} : dly;
  wire logic [WW-1:0]   chain = {ds1_r, ds0_r};
  wire logic [WW-1:0]   lmask = f_mask(weff);
  // (R10) (R11) Lanes or cascade
  wire logic [WW-1:0]   rx_w  = cas ? (chain & lmask)
                                    : {ds1_r & lmask[3:0], ds0_r & lmask[3:0]};
  // (R12) (R13) Bit leaving each serialiser
  wire logic [NP-1:0]   sb    = {sreg_r[3'(weff + 4'h3)], sreg_r[3'(weff - 4'h1)]};
  wire logic [NP-1:0]   o_pre = cfg_l.ser_en ? sb : tx_bit;
  // (R1) Output path selection
  wire logic [NP-1:0]   o_sel = cfg_l.out_reg ? o_r : o_pre;
  wire logic [NP-1:0]   pd_on = {1'b0, cfg_l.pd_en && cfg_l.diff_en};
  wire logic [NP-1:0]   busy_l;

  // (R13) Differential drive pairs the pins
  wire logic [NP-1:0]   pin_o = cfg_l.diff_en ? {~dly[0], dly[0]} : dly;
  // (R16) (R17) Drive only when outbound
  wire logic [NP-1:0]   pin_oe = {NP{dir}};

  assign pins     = {pin_o, pin_oe};
  // (R1) Input path selection
  assign rx_bit   = cfg_l.in_reg ? rxb_r : d_in;
  assign tx_ready = (txq_r == ack_s2_r);
  assign rx_word  = rx_word_r;
  assign rx_valid = rx_valid_r;
  assign cal_busy = busy_s2_r;

  // ****************************************
  // Delay lines, one per pin
  // ****************************************
  for (genvar k = 0; k < NP; k++) begin : g_pin
    idst_tap_req_t req;
    assign req = {qp[k], qp[NP+k], qp[2*NP+k]};
    // (R3) Per-pin delay
    idst_tap_line #(
      .DEPTH (TAP_DEPTH),
      .INIT  (TAP_INIT)
    ) u_line (
      .io_clk   (io_clk),
      .rst_n    (lrst_n_r),
      .dir_out  (dir),
      .din_in   (pin_s2_r[k]),
      .din_out  (o_sel[k]),
      .dout     (dly[k]),
      .strobe   (strobe),
      .req      (req),
      .pd_en    (pd_on[k]),
      .tap      (tap_value[k]),
      .cal_busy (busy_l[k])
    );
  end

  // ****************************************
  // Link-side logic
  // ****************************************
  assign cnt_nxt = !strobe ? cnt_r : (bnd ? 4'h0 : cnt_r + 4'h1);

  // (R14) One edge, shift or load
  always_comb begin
    sreg_nxt = sreg_r;
    if (bnd) sreg_nxt = pend_r ? pw_r : '0;
    else if (strobe && cas) sreg_nxt = sreg_r << 1;
    else if (strobe) sreg_nxt = {sreg_r[6:4], 1'b0, sreg_r[2:0], 1'b0};
  end

  // Reset release is synchronised so the link side leaves reset cleanly
  always_ff @(posedge io_clk or negedge arst_n) begin
    if (!arst_n) begin
      lrst_s1_r <= 1'b0;
      lrst_n_r  <= 1'b0;
    end else begin
      lrst_s1_r <= 1'b1;
      lrst_n_r  <= lrst_s1_r;
    end
  end

  // Config is quasi-static: change it only while the link is idle
  always_ff @(posedge io_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      cfg_s1_r <= '0;
      cfg_l    <= '0;
      qs1_r    <= '0;
      qs2_r    <= '0;
      qs3_r    <= '0;
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      ck_s1_r  <= 1'b0;
      ck_s2_r  <= 1'b0;
      ck_s3_r  <= 1'b0;
      txq_s1_r <= 1'b0;
      txq_s2_r <= 1'b0;
    end else begin
      cfg_s1_r <= cfg;
      cfg_l    <= cfg_s1_r;
      qs1_r    <= qt_r;
      qs2_r    <= qs1_r;
      qs3_r    <= qs2_r;
      pin_s1_r <= pin_i;
      pin_s2_r <= pin_s1_r;
      ck_s1_r  <= ddr_clk_i;
      ck_s2_r  <= ck_s1_r;
      ck_s3_r  <= ck_s2_r;
      txq_s1_r <= txq_r;
      txq_s2_r <= txq_s1_r;
    end
  end

  // (R12) Word taken from the core
  always_ff @(posedge io_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      ack_r  <= 1'b0;
      pend_r <= 1'b0;
      pw_r   <= '0;
      sreg_r <= '0;
      cnt_r  <= 4'h0;
      o_r    <= '0;
    end else begin
      if (take) ack_r <= txq_s2_r;
      if (take) pw_r <= txh_r;
      pend_r <= take || (pend_r && !bnd);
      sreg_r <= sreg_nxt;
      cnt_r  <= cnt_nxt;
      o_r    <= o_pre;
    end
  end

  // (R10) (R11) Deserialisers, slave fed by master when cascaded
  always_ff @(posedge io_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      ds0_r <= 4'h0;
      ds1_r <= 4'h0;
      rxh_r <= '0;
      rxt_r <= 1'b0;
      rxb_r <= '0;
    end else begin
      if (strobe && !dir) ds0_r <= {ds0_r[2:0], d_in[0]};
      if (strobe && !dir) ds1_r <= {ds1_r[2:0], cas ? ds0_r[3] : d_in[1]};
      if (bnd && !dir) rxh_r <= rx_w;
      if (bnd && !dir) rxt_r <= ~rxt_r;
      rxb_r <= d_in;
    end
  end

  // ****************************************
  // Core-side logic
  // ****************************************
  // Toggles carry request pulses; each must be followed by a quiet gap
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      qt_r  <= '0;
      txh_r <= '0;
      txq_r <= 1'b0;
    end else begin
      qt_r <= qt_r ^ {cal_start, tap_dec, tap_inc};
      if (tx_valid && tx_ready) txh_r <= tx_word;
      if (tx_valid && tx_ready) txq_r <= ~txq_r;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_s1_r   <= 1'b0;
      ack_s2_r   <= 1'b0;
      rxt_s1_r   <= 1'b0;
      rxt_s2_r   <= 1'b0;
      rxt_s3_r   <= 1'b0;
      rx_word_r  <= '0;
      rx_valid_r <= 1'b0;
      busy_s1_r  <= 1'b0;
      busy_s2_r  <= 1'b0;
    end else begin
      ack_s1_r   <= ack_r;
      ack_s2_r   <= ack_s1_r;
      rxt_s1_r   <= rxt_r;
      rxt_s2_r   <= rxt_s1_r;
      rxt_s3_r   <= rxt_s2_r;
      rx_valid_r <= rxt_s2_r ^ rxt_s3_r;
      if (rxt_s2_r ^ rxt_s3_r) rx_word_r <= rxh_r;
      busy_s1_r  <= |busy_l;
      busy_s2_r  <= busy_s1_r;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_tx_hold;
    @(posedge clock) disable iff (!arst_n)
    tx_valid && tx_ready |=> !tx_ready [*3];
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("ready back too soon"); // (R12)

  property p_rx_pulse;
    @(posedge clock) disable iff (!arst_n)
    rx_valid |=> !rx_valid;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("word valid held"); // (R10)

  property p_load;
    @(posedge io_clk) disable iff (!lrst_n_r)
    bnd && pend_r |=> sreg_r == $past(pw_r);
  endproperty
  a_load: assert property (p_load) else $error("serialiser missed word"); // (R12)

  property p_diff;
    @(posedge io_clk) disable iff (!lrst_n_r)
    cfg_l.diff_en |-> pins.o[1] != pins.o[0];
  endproperty
  a_diff: assert property (p_diff) else $error("pair not complementary"); // (R13)

  property p_one_edge;
    @(posedge io_clk) disable iff (!lrst_n_r)
    !strobe |=> $stable(sreg_r) && $stable(cnt_r);
  endproperty
  a_one_edge: assert property (p_one_edge) else $error("shift off strobe"); // (R14)

  property p_in_reg;
    @(posedge io_clk) disable iff (!lrst_n_r)
    cfg_l.in_reg ##1 cfg_l.in_reg |-> rx_bit == $past(d_in);
  endproperty
  a_in_reg: assert property (p_in_reg) else $error("input not registered"); // (R1)

endmodule

`default_nettype wire

// >>> verif/idst_partner.sv
// Far-side serial device: drives a repeating pattern and a partner clock
// Assumes io_clk from the bench; yields the pins whenever the tile drives
`timescale 1ns/1ps
`default_nettype none
`include "idst_defs.svh"

module idst_partner
  import idst_pkg::*;
(
  // Link clock and controls
  input  wire logic                  io_clk,
  input  wire logic [3:0]            period,
  input  wire logic                  clk_run,
  // Pins
  input  wire idst_pin_t             pins,
  output logic [`IDST_PINS-1:0]      pin_i,
  output logic                       ddr_clk_i
);
  logic [3:0] pos_r;
  logic [1:0] div_r;
  logic       bit0;

  initial begin
    pos_r     = 4'h0;
    div_r     = 2'h0;
    ddr_clk_i = 1'b0;
  end

  // Pattern of period-1 ones and one zero, so any word alignment is checkable
  always @(posedge io_clk) begin
    pos_r <= (pos_r + 4'h1 >= period) ? 4'h0 : pos_r + 4'h1;
  end
  assign bit0 = (pos_r != 4'h0);

  // Partner clock stands still unless a calibration wants it
  always @(posedge io_clk) begin
    if (clk_run) begin
      div_r <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
      if (div_r == 2'h2) begin
        ddr_clk_i <= ~ddr_clk_i;
      end
    end
  end

  // ********************
  // Wire resolution
  // ********************
  // Both ways
  assign pin_i[0] = pins.oe[0] ? pins.o[0] : bit0;
  assign pin_i[1] = pins.oe[1] ? pins.o[1] : 1'b0;
endmodule
`default_nettype wire

// >>> verif/tb_idst_tile.sv
// Self-checking bench for the delay and serdes tile
// Assumes idst_partner on the far side and a 16-tap delay line
`timescale 1ns/1ps
`default_nettype none
`include "idst_defs.svh"

module tb_idst_tile
  import idst_pkg::*;
;
  logic                               clock = 1'b0;
  logic                               io_clk = 1'b0;
  logic                               arst_n = 1'b0;
  idst_cfg_t                          cfg = '0;
  logic [`IDST_PINS-1:0]              tap_inc = '0;
  logic [`IDST_PINS-1:0]              tap_dec = '0;
  logic [`IDST_PINS-1:0]              cal_start = '0;
  logic                               cal_busy;
  logic [`IDST_WORD_W-1:0]            tx_word = '0;
  logic                               tx_valid = 1'b0;
  logic                               tx_ready;
  logic [`IDST_WORD_W-1:0]            rx_word;
  logic                               rx_valid;
  logic [`IDST_PINS-1:0]              rx_bit;
  logic [`IDST_PINS-1:0][3:0]         tap_value;
  logic                               ddr_clk_i;
  logic [`IDST_PINS-1:0]              pin_i;
  idst_pin_t                          pins;
  logic [3:0]                         period = 4'h4;
  logic                               clk_run = 1'b0;
  logic [31:0]                        hist = '0;
  int                                 failures = 0;
  int                                 samples_checked = 0;

  always #4 clock = ~clock;
  initial #13 forever #40 io_clk = ~io_clk;
  always @(posedge io_clk) hist <= {hist[30:0], pins.o[0]};

  idst_tile #(.TAP_DEPTH(16), .TAP_INIT(0)) uut (
    .clock(clock), .arst_n(arst_n), .cfg(cfg), .tap_inc(tap_inc), .tap_dec(tap_dec),
    .cal_start(cal_start), .cal_busy(cal_busy), .tx_word(tx_word), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid), .io_clk(io_clk),
    .tx_bit(2'b00), .rx_bit(rx_bit), .tap_value(tap_value), .ddr_clk_i(ddr_clk_i),
    .pin_i(pin_i), .pins(pins));

  idst_partner far (.io_clk(io_clk), .period(period), .clk_run(clk_run), .pins(pins),
    .pin_i(pin_i), .ddr_clk_i(ddr_clk_i));

  // ********************
  // Shared tasks
  // ********************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // Bounded wait: 0 rx_valid high, 1 cal_busy high, 2 cal_busy low
  task automatic wait_on(input int sel);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (!((sel == 0 && rx_valid === 1'b1) || (sel == 1 && cal_busy === 1'b1) ||
                 (sel == 2 && cal_busy === 1'b0)) && n < 2000);
    if (n >= 2000) begin
      check(1'b0, "wait ran out");
      finish_test();
    end
  endtask

  // Config changes only while idle; then let the link synchronisers settle
  task automatic set_cfg(input logic oe_v, input logic diff_v, input logic dbl_v,
                         input logic [3:0] w);
    @(posedge clock);
    cfg <= '{ser_en: 1'b1, in_reg: diff_v, out_reg: diff_v, ddr_en: 1'b0,
             diff_en: diff_v, pd_en: 1'b0, dbl_src: dbl_v, out_en: oe_v, width: w};
    // Long enough that no word shifted under the old setting is still in flight
    repeat (120) @(posedge clock);
  endtask

  // kind 0 increment, 1 decrement, 2 calibrate; spaced per the request order
  task automatic tap_req(input int kind);
    @(posedge clock);
    tap_inc[0] <= (kind == 0);
    tap_dec[0] <= (kind == 1);
    cal_start[0] <= (kind == 2);
    @(posedge clock);
    tap_inc <= '0;
    tap_dec <= '0;
    cal_start <= '0;
    repeat (40) @(posedge clock);
  endtask

  logic [3:0] wl [4] = '{4'h2, 4'h3, 4'h4, 4'h8};
  logic [7:0] txw [2] = '{8'h0A, 8'hB5};
  logic       hit;

  initial begin
    // Judged while held: once released the inbound stream starts pulsing rx_valid
    repeat (40) @(posedge clock);
    #1;
    check(tx_ready === 1'b1 && rx_valid === 1'b0 && cal_busy === 1'b0, "reset outs");
    check(pins.oe === 2'b00 && tap_value[0] === 4'h0, "reset pins");
    @(posedge clock);
    arst_n <= 1'b1;
    repeat (40) @(posedge clock);
    $display("test reset done");

    // Saturating steps of a 16-tap line
    tap_req(1);
    check(tap_value[0] === 4'h0, "dec at zero");
    for (int i = 0; i < 16; i++) begin
      tap_req(0);
    end
    check(tap_value[0] === 4'hF, "inc at top");
    tap_req(1);
    check(tap_value[0] === 4'hE && tap_value[1] === 4'h0, "dec one");
    $display("test taps done");

    // Partner clock half period of 3 io cycles: odd count loads 1
    set_cfg(1'b0, 1'b0, 1'b1, 4'h4);
    clk_run <= 1'b1;
    tap_req(2);
    wait_on(1);
    wait_on(2);
    check(tap_value[0] === 4'h1, "half period");
    clk_run <= 1'b0;
    $display("test calibrate done");

    // Widths 2, 3, 4 and 8, one zero per word, lane 1 stays empty unless cascaded
    for (int i = 0; i < 4; i++) begin
      period <= wl[i];
      set_cfg(1'b0, wl[i] > 4'h4, 1'b0, wl[i]);
      check(pins.oe === 2'b00, "inbound drives");
      wait_on(0);
      wait_on(0);
      check((rx_word >> wl[i]) === 8'h00 && $countones(rx_word) == wl[i] - 1 &&
            !$isunknown(rx_word), "rx word");
      // Registered input path lags the line output by one link cycle
      check(rx_bit === (wl[i] > 4'h4 ? {2{hist[0]}} : {1'b0, pins.o[0]}),
            "input path");
    end
    $display("test receive done");

    // Words sent MSB first into a zero stream; cascade drives complement
    for (int i = 0; i < 2; i++) begin
      set_cfg(1'b1, i == 1, 1'b0, i ? 4'h8 : 4'h4);
      check(pins.oe === 2'b11, "outbound drives");
      check(tx_ready === 1'b1, "ready idle");
      @(posedge clock);
      tx_word <= txw[i];
      tx_valid <= 1'b1;
      @(posedge clock);
      tx_valid <= 1'b0;
      repeat (250) @(posedge clock);
      hit = 1'b0;
      for (int k = 0; k < 24; k++) begin
        if (i == 0 && hist[k +: 4] === 4'hA) hit = 1'b1;
        if (i == 1 && hist[k +: 8] === 8'hB5) hit = 1'b1;
      end
      check(hit, "serial word");
      if (i == 1) check(pins.o[1] === ~pins.o[0], "pair complement");
    end
    $display("test transmit done");
    finish_test();
  end
endmodule
`default_nettype wire
